/* inc/eit_defines.svh */
`ifndef EIT_DEFINES_SVH
`define EIT_DEFINES_SVH

// Bit positions in the first source enable register.
`define EIT_V1_EXT0 0
`define EIT_V1_EXT1 1
`define EIT_V1_T2 3

// Bit positions in each external pin control register.
`define EIT_IC_BOTH 1
`define EIT_IC_POL 2
`define EIT_IC_EN 3

// Timer-2 control fields.
`define EIT_W2_RUN 2
`define EIT_W2_SRC_HI 1
`define EIT_W2_SRC_LO 0
`define EIT_SRC_INSTR 2'h0
`define EIT_SRC_PRESC 2'h1

// Reset values.
`define EIT_NIB_RST 4'h0
`define EIT_BYTE_RST 8'h00
`define EIT_BYTE_MAX 8'hFF
`define EIT_P3_RST 2'h3

// One instruction cycle is this many system clocks.
`define EIT_INSTR_CLKS 3
`define EIT_ICYC_LAST 2'h2

`endif

/* inc/eit_pkg.sv */
package eit_pkg;

    // Instructions that reach this block from the core's decoder.
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_DISABLE_ALL_IRQ = 4'h1,
        OP_ENABLE_ALL_IRQ = 4'h2,
        OP_SKIP_TEST_EXT0 = 4'h3,
        OP_SKIP_TEST_EXT1 = 4'h4,
        OP_SKIP_TEST_TIMER_TWO = 4'h5,
        OP_WRITE_SOURCE_ENABLE = 4'h6,
        OP_WRITE_EXT0_CTRL = 4'h7,
        OP_WRITE_EXT1_CTRL = 4'h8,
        OP_WRITE_PORT3 = 4'h9,
        OP_WRITE_TIMER_TWO_CTRL = 4'hA,
        OP_WRITE_PRESCALER_CTRL = 4'hB,
        OP_LOAD_TIMER_TWO_RELOAD = 4'hC,
        OP_LOAD_PRESCALER_RELOAD = 4'hD
    } eit_op_t;

    // One instruction with the accumulator and the B register.
    typedef struct packed {
        eit_op_t op;
        logic [3:0] acc;
        logic [3:0] breg;
    } eit_cmd_t;

    // Which source the core is vectored to.
    typedef enum logic [1:0] {
        SRC_NONE = 2'h0,
        SRC_EXT0 = 2'h1,
        SRC_EXT1 = 2'h2,
        SRC_TIMER_TWO = 2'h3
    } eit_src_t;

    // Readable state of the block.
    typedef struct packed {
        logic inte;
        logic [3:0] source_enable;
        logic [3:0] ext0_ctrl;
        logic [3:0] ext1_ctrl;
        logic [3:0] timer_two_ctrl;
        logic prescaler_run;
        logic ext0_flag;
        logic ext1_flag;
        logic timer_two_flag;
        logic [7:0] timer_two_count;
    } eit_stat_t;

endpackage

/* rtl/eit_edge_det.sv */
`timescale 1ns/100ps
`include "eit_defines.svh"

// Pin synchroniser and valid-waveform detector for one external pin.
module eit_edge_det (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Raw pin and its control register.
    input wire logic pin,
    input wire logic [3:0] ctrl,
    // Request pulse, one cycle.
    output logic edge_hit
);

    logic sync1_r;
    logic sync2_r;
    logic valid_r;
    logic valid_lvl;

    // Two flops bring the pin into the clock domain.
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            valid_r <= 1'b0;
        end else begin
            sync1_r <= pin;
            sync2_r <= sync1_r; // [RULE_19]
            valid_r <= valid_lvl;
        end
    end

    // The gated, polarity-corrected level; a change of enable or polarity
    // can move it, which is why a control write may raise a request.
    assign valid_lvl = ctrl[`EIT_IC_EN] & // [RULE_07] [RULE_16]
        (ctrl[`EIT_IC_POL] ? sync2_r : ~sync2_r);

    // Both-edge mode flags any change, otherwise only the active edge.
    assign edge_hit = ctrl[`EIT_IC_BOTH] ? (valid_lvl ^ valid_r) : // [RULE_08]
        (valid_lvl & ~valid_r); // [RULE_09]

endmodule // eit_edge_det

/* rtl/eit_irq_top.sv */
// Notes on behaviour
// (RULE_01) Sources hold a valid level or edge state at least four clocks.
// (RULE_02) Source enable bit 0 gates the external-0 request.
// (RULE_03) Source enable bit 1 gates the external-1 request.
// (RULE_04) Source enable bit 3 gates the timer-2 request.
// (RULE_05) Global enable set and cleared by instructions; zero blocks every source.
// (RULE_06) Software writes port latch 1 before using the pin as input.
// (RULE_07) Pin control bit 3 enables the pin input path.
// (RULE_08) Pin control bit 1 set detects both edges.
// (RULE_09) Bits 1 and 2 both zero detect falling edges only.
// (RULE_10) The external-0 skip-test instruction clears its request flag; here only while source enable bit 0 is 0.
// (RULE_11) Skip-test skips the next instruction when set; software adds a no-op; here only while that source's enable bit is 0.
// (RULE_12) Timer-2 control bit 2 starts and stops timer 2.
// (RULE_13) Timer-2 control bits 1:0 pick the count source; 01 is prescaler.
// (RULE_14) Timer-2 and prescaler reload registers take software count values.
// (RULE_15) Timer-2 request flag is cleared by its skip-test instruction; here only while source enable bit 3 is 0.
// (RULE_16) Changing polarity or input enable may set the request flag.
// (RULE_17) Timer 2 sets its request flag on every underflow.
// (RULE_18) Instruction cycle is three clocks; prescaler divides by reload plus one.
// (RULE_19) Pins are synchronised; each held transition is caught exactly once.
// (RULE_20) Timer 2 reloads itself on underflow and keeps counting.
`timescale 1ns/100ps
`include "eit_defines.svh"

module eit_irq_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Instruction strobe from the core.
    input wire logic cmd_valid,
    input wire eit_pkg::eit_cmd_t cmd,
    // Interrupt handshake with the core.
    input wire logic irq_ack,
    output logic irq_req,
    output eit_pkg::eit_src_t irq_src,
    // Skip of the following instruction, one-cycle pulse.
    output logic skip_next,
    // External interrupt pins, open drain through the port latch.
    input wire logic ext_irq_pin_zero_in,
    output logic ext_irq_pin_zero_out,
    output logic ext_irq_pin_zero_oe_n,
    input wire logic ext_irq_pin_one_in,
    output logic ext_irq_pin_one_out,
    output logic ext_irq_pin_one_oe_n,
    // Block state and the prescaler output tick.
    output eit_pkg::eit_stat_t status,
    output logic prescaler_output_clock
);

    logic [3:0] source_enable_r;
    logic [3:0] ext0_ctrl_r;
    logic [3:0] ext1_ctrl_r;
    logic [3:0] timer_two_ctrl_r;
    logic prescaler_run_r;
    logic [7:0] timer_two_reload_r;
    logic [7:0] prescaler_reload_r;
    logic [7:0] timer_two_cnt_r;
    logic [7:0] timer_two_cnt_nxt;
    logic [7:0] presc_cnt_r;
    logic [7:0] presc_cnt_nxt;
    logic [1:0] icyc_r;
    logic inte_r;
    logic inte_nxt;
    logic ext0_flag_r;
    logic ext0_flag_nxt;
    logic ext1_flag_r;
    logic ext1_flag_nxt;
    logic t2_flag_r;
    logic t2_flag_nxt;
    logic [1:0] port3_latch_r;
    logic skip_r;
    logic skip_nxt;

    // Decoded instruction strobes.
    logic op_di;
    logic op_ei;
    logic op_skip_test_ext0_instr;
    logic op_skip_test_ext1_instr;
    logic op_skip_test_timer_two_instr;
    logic wr_v1;
    logic wr_i1;
    logic wr_i2;
    logic wr_p3;
    logic wr_w2;
    logic wr_pa;
    logic ld_t2;
    logic ld_ps;
    logic [7:0] cmd_byte;

    assign op_di = cmd_valid && cmd.op == eit_pkg::OP_DISABLE_ALL_IRQ;
    assign op_ei = cmd_valid && cmd.op == eit_pkg::OP_ENABLE_ALL_IRQ;
    assign op_skip_test_ext0_instr = cmd_valid && cmd.op == eit_pkg::OP_SKIP_TEST_EXT0;
    assign op_skip_test_ext1_instr = cmd_valid && cmd.op == eit_pkg::OP_SKIP_TEST_EXT1;
    assign op_skip_test_timer_two_instr = cmd_valid &&
        cmd.op == eit_pkg::OP_SKIP_TEST_TIMER_TWO;
    assign wr_v1 = cmd_valid && cmd.op == eit_pkg::OP_WRITE_SOURCE_ENABLE;
    assign wr_i1 = cmd_valid && cmd.op == eit_pkg::OP_WRITE_EXT0_CTRL;
    assign wr_i2 = cmd_valid && cmd.op == eit_pkg::OP_WRITE_EXT1_CTRL;
    assign wr_p3 = cmd_valid && cmd.op == eit_pkg::OP_WRITE_PORT3;
    assign wr_w2 = cmd_valid && cmd.op == eit_pkg::OP_WRITE_TIMER_TWO_CTRL;
    assign wr_pa = cmd_valid && cmd.op == eit_pkg::OP_WRITE_PRESCALER_CTRL;
    assign ld_t2 = cmd_valid && cmd.op == eit_pkg::OP_LOAD_TIMER_TWO_RELOAD;
    assign ld_ps = cmd_valid && cmd.op == eit_pkg::OP_LOAD_PRESCALER_RELOAD;
    // The byte loads take the accumulator as the high nibble.
    assign cmd_byte = {cmd.acc, cmd.breg};

    // Control registers written through the accumulator.
    always_ff @(posedge clk) begin
        if (rst) begin
            source_enable_r <= `EIT_NIB_RST;
            ext0_ctrl_r <= `EIT_NIB_RST;
            ext1_ctrl_r <= `EIT_NIB_RST;
            timer_two_ctrl_r <= `EIT_NIB_RST;
            prescaler_run_r <= 1'b0;
            port3_latch_r <= `EIT_P3_RST;
        end else begin
            if (wr_v1) source_enable_r <= cmd.acc;
            if (wr_i1) ext0_ctrl_r <= cmd.acc; // [RULE_07] [RULE_16]
            if (wr_i2) ext1_ctrl_r <= cmd.acc;
            if (wr_w2) timer_two_ctrl_r <= cmd.acc;
            if (wr_pa) prescaler_run_r <= cmd.acc[0];
            if (wr_p3) port3_latch_r <= cmd.acc[1:0];
        end
    end

    // Reload registers; a load also presets a stopped counter.
    always_ff @(posedge clk) begin
        if (rst) begin
            timer_two_reload_r <= `EIT_BYTE_MAX;
            prescaler_reload_r <= `EIT_BYTE_MAX;
        end else begin
            if (ld_t2) timer_two_reload_r <= cmd_byte; // [RULE_14]
            if (ld_ps) prescaler_reload_r <= cmd_byte; // [RULE_14]
        end
    end

    // Port latch: a 0 pulls the pin low, a 1 lets it act as an input.
    assign ext_irq_pin_zero_out = 1'b0;
    assign ext_irq_pin_one_out = 1'b0;
    assign ext_irq_pin_zero_oe_n = port3_latch_r[0];
    assign ext_irq_pin_one_oe_n = port3_latch_r[1];

    // Pin synchronisers and waveform detectors, one per pin.
    logic ext0_hit;
    logic ext1_hit;

    eit_edge_det u_ext0 (
        .clk(clk),
        .rst(rst),
        .pin(ext_irq_pin_zero_in),
        .ctrl(ext0_ctrl_r),
        .edge_hit(ext0_hit)
    ); // [RULE_19] [RULE_01]

    eit_edge_det u_ext1 (
        .clk(clk),
        .rst(rst),
        .pin(ext_irq_pin_one_in),
        .ctrl(ext1_ctrl_r),
        .edge_hit(ext1_hit)
    ); // [RULE_08] [RULE_09]

    // Instruction clock: one tick every third system clock.
    logic instr_tick;
    assign instr_tick = icyc_r == `EIT_ICYC_LAST; // [RULE_18]

    always_ff @(posedge clk) begin
        if (rst) begin
            icyc_r <= 2'h0;
        end else begin
            icyc_r <= instr_tick ? 2'h0 : icyc_r + 2'h1;
        end
    end

    // Prescaler counts instruction ticks, dividing by reload plus one.
    logic presc_tick;
    assign presc_tick = prescaler_run_r && instr_tick &&
        presc_cnt_r == `EIT_BYTE_RST; // [RULE_18]
    assign prescaler_output_clock = presc_tick;

    always_comb begin
        presc_cnt_nxt = presc_cnt_r;
        if (!prescaler_run_r && ld_ps) begin
            presc_cnt_nxt = cmd_byte;
        end else if (presc_tick) begin
            presc_cnt_nxt = prescaler_reload_r;
        end else if (prescaler_run_r && instr_tick) begin
            presc_cnt_nxt = presc_cnt_r - 8'h01;
        end
    end

    // Count source of timer 2; codes other than the two known stall it.
    logic t2_src_tick;
    logic t2_run;
    logic t2_under;
    assign t2_run = timer_two_ctrl_r[`EIT_W2_RUN]; // [RULE_12]
    assign t2_src_tick = (timer_two_ctrl_r[1:0] == `EIT_SRC_PRESC) ?
        presc_tick : // [RULE_13]
        ((timer_two_ctrl_r[1:0] == `EIT_SRC_INSTR) && instr_tick);
    // Codes 10 and 11 leave timer 2 with no source at all.
    assign t2_under = t2_run && t2_src_tick &&
        timer_two_cnt_r == `EIT_BYTE_RST;

    always_comb begin
        timer_two_cnt_nxt = timer_two_cnt_r;
        if (!t2_run && ld_t2) begin
            timer_two_cnt_nxt = cmd_byte;
        end else if (t2_under) begin
            timer_two_cnt_nxt = timer_two_reload_r; // [RULE_20]
        end else if (t2_run && t2_src_tick) begin
            timer_two_cnt_nxt = timer_two_cnt_r - 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            presc_cnt_r <= `EIT_BYTE_MAX;
            timer_two_cnt_r <= `EIT_BYTE_MAX;
        end else begin
            presc_cnt_r <= presc_cnt_nxt;
            timer_two_cnt_r <= timer_two_cnt_nxt;
        end
    end

    // A skip test only works while its source is disabled; when enabled
    // the instruction behaves as a no-op and leaves the flag alone.
    logic skip_test_ext0_instr_hit;
    logic skip_test_ext1_instr_hit;
    logic skip_test_timer_two_instr_hit;
    assign skip_test_ext0_instr_hit = op_skip_test_ext0_instr && !source_enable_r[`EIT_V1_EXT0] &&
        ext0_flag_r;
    assign skip_test_ext1_instr_hit = op_skip_test_ext1_instr && !source_enable_r[`EIT_V1_EXT1] &&
        ext1_flag_r;
    assign skip_test_timer_two_instr_hit = op_skip_test_timer_two_instr && !source_enable_r[`EIT_V1_T2] &&
        t2_flag_r;

    // Gated requests and the fixed priority seen by the core.
    logic [2:0] pend;
    assign pend[0] = ext0_flag_r && source_enable_r[`EIT_V1_EXT0]; // [RULE_02]
    assign pend[1] = ext1_flag_r && source_enable_r[`EIT_V1_EXT1]; // [RULE_03]
    assign pend[2] = t2_flag_r && source_enable_r[`EIT_V1_T2]; // [RULE_04]
    assign irq_req = inte_r && (|pend); // [RULE_05]
    assign irq_src = !irq_req ? eit_pkg::SRC_NONE :
        pend[0] ? eit_pkg::SRC_EXT0 :
        pend[1] ? eit_pkg::SRC_EXT1 : eit_pkg::SRC_TIMER_TWO;

    // Acceptance clears the serviced flag and the global enable.
    logic ack0;
    logic ack1;
    logic ackt2;
    assign ack0 = irq_ack && irq_src == eit_pkg::SRC_EXT0;
    assign ack1 = irq_ack && irq_src == eit_pkg::SRC_EXT1;
    assign ackt2 = irq_ack && irq_src == eit_pkg::SRC_TIMER_TWO;

    // Flag updates; a new event wins over a clear in the same cycle.
    assign ext0_flag_nxt = ext0_hit |
        (ext0_flag_r & ~(skip_test_ext0_instr_hit | ack0)); // [RULE_10]
    assign ext1_flag_nxt = ext1_hit | (ext1_flag_r & ~(skip_test_ext1_instr_hit | ack1));
    assign t2_flag_nxt = t2_under |
        (t2_flag_r & ~(skip_test_timer_two_instr_hit | ackt2)); // [RULE_15] [RULE_17]
    assign inte_nxt = op_ei ? 1'b1 :
        ((op_di || (irq_ack && irq_req)) ? 1'b0 : inte_r); // [RULE_05]
    assign skip_nxt = skip_test_ext0_instr_hit | skip_test_ext1_instr_hit | skip_test_timer_two_instr_hit; // [RULE_11]

    always_ff @(posedge clk) begin
        if (rst) begin
            ext0_flag_r <= 1'b0;
            ext1_flag_r <= 1'b0;
            t2_flag_r <= 1'b0;
            inte_r <= 1'b0;
            skip_r <= 1'b0;
        end else begin
            ext0_flag_r <= ext0_flag_nxt;
            ext1_flag_r <= ext1_flag_nxt;
            t2_flag_r <= t2_flag_nxt;
            inte_r <= inte_nxt;
            skip_r <= skip_nxt;
        end
    end

    assign skip_next = skip_r;

    // Status view of the block.
    assign status.inte = inte_r;
    assign status.source_enable = source_enable_r;
    assign status.ext0_ctrl = ext0_ctrl_r;
    assign status.ext1_ctrl = ext1_ctrl_r;
    assign status.timer_two_ctrl = timer_two_ctrl_r;
    assign status.prescaler_run = prescaler_run_r;
    assign status.ext0_flag = ext0_flag_r;
    assign status.ext1_flag = ext1_flag_r;
    assign status.timer_two_flag = t2_flag_r;
    assign status.timer_two_count = timer_two_cnt_r;

    // Checks on the logic above.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_ext0_held_disabled;
        (!ext0_ctrl_r[`EIT_IC_EN] && !wr_i1) [*4];
    endsequence

    sequence s_ext1_falling_mode;
        (ext1_ctrl_r[`EIT_IC_EN] && !ext1_ctrl_r[`EIT_IC_POL] &&
            !ext1_ctrl_r[`EIT_IC_BOTH] && !wr_i2) [*4];
    endsequence

    sequence s_t2_underflow;
        t2_under ##1 t2_flag_r;
    endsequence

    chk_ext0_source_gate: assert property ( // [RULE_02]
        !source_enable_r[`EIT_V1_EXT0] && !pend[1] && !pend[2]
        |-> !irq_req)
        else $error("external-0 request passed a cleared enable bit");

    chk_ext1_source_gate: assert property ( // [RULE_03]
        irq_src == eit_pkg::SRC_EXT1
        |-> source_enable_r[`EIT_V1_EXT1] && ext1_flag_r)
        else $error("external-1 vectored without its enable and flag");

    chk_t2_source_gate: assert property ( // [RULE_04]
        irq_src == eit_pkg::SRC_TIMER_TWO
        |-> source_enable_r[`EIT_V1_T2] && t2_flag_r && inte_r)
        else $error("timer-2 vectored without its enable and flag");

    chk_global_enable_off: assert property ( // [RULE_05]
        op_di && !op_ei |=> !inte_r ##0 !irq_req)
        else $error("request seen after global disable");

    chk_pin_disabled_quiet: assert property ( // [RULE_07]
        s_ext0_held_disabled |-> !ext0_hit)
        else $error("disabled external-0 pin raised a request");

    chk_falling_only: assert property ( // [RULE_09]
        s_ext1_falling_mode ##0 ext1_hit
        |-> $past(ext_irq_pin_one_in, 2) == 1'b0 &&
            $past(ext_irq_pin_one_in, 3) == 1'b1)
        else $error("falling mode fired on a wrong transition");

    chk_skip_clears_ext0: assert property ( // [RULE_10] [RULE_11]
        skip_test_ext0_instr_hit && !ext0_hit |=> !ext0_flag_r && skip_next)
        else $error("external-0 skip test did not clear and skip");

    chk_set_beats_clear: assert property ( // [RULE_10]
        ext0_hit && (skip_test_ext0_instr_hit || ack0) |=> ext0_flag_r)
        else $error("external-0 event lost against a clear");

    chk_t2_stopped_hold: assert property ( // [RULE_12]
        !t2_run && !ld_t2 && !wr_w2 |=> $stable(timer_two_cnt_r))
        else $error("timer 2 moved while stopped");

    chk_t2_reload_flag: assert property ( // [RULE_17] [RULE_20]
        s_t2_underflow
        |-> timer_two_cnt_r == $past(timer_two_reload_r))
        else $error("timer 2 did not reload on underflow");

    chk_instr_three_clks: assert property ( // [RULE_18]
        instr_tick |=> !instr_tick ##1 !instr_tick ##1 instr_tick)
        else $error("instruction tick not every three clocks");

    chk_presc_source: assert property ( // [RULE_13]
        t2_run && timer_two_ctrl_r[1:0] == `EIT_SRC_PRESC && !presc_tick
        && !ld_t2 && !wr_w2 |=> $stable(timer_two_cnt_r))
        else $error("timer 2 counted without a prescaler tick");

    chk_t2_skip_clear: assert property ( // [RULE_15]
        skip_test_timer_two_instr_hit && !t2_under |=> !t2_flag_r ##0 skip_next)
        else $error("timer-2 skip test did not clear its flag");

endmodule // eit_irq_top

/* verification/eit_pin_src.sv */
`timescale 1ns/100ps

// Two external sources that drive the interrupt pins of the block.
module eit_pin_src (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Level that the bench asks each source to reach.
    input wire logic [1:0] want,
    // Device side of the open-drain pins.
    input wire logic [1:0] dev_out,
    input wire logic [1:0] dev_oe_n,
    // Resolved wire levels.
    output logic [1:0] pin
);
    logic [1:0] lvl_r;
    logic [2:0] hold_r [2];

    // A source only moves after its level has stood four clocks, so a
    // bench that asks too early is slowed down, never obeyed at once.
    always_ff @(posedge clk) begin
        for (int i = 0; i < 2; i++) begin
            if (rst) begin
                lvl_r[i] <= 1'b1;
                hold_r[i] <= 3'h0;
            end else if (want[i] != lvl_r[i] && hold_r[i] >= 3'h3) begin
                lvl_r[i] <= want[i];
                hold_r[i] <= 3'h0;
            end else if (hold_r[i] != 3'h7) begin
                hold_r[i] <= hold_r[i] + 3'h1;
            end
        end
    end

    // The device pulls the wire low whenever its driver is on.
    assign pin[0] = dev_oe_n[0] ? lvl_r[0] : dev_out[0];
    assign pin[1] = dev_oe_n[1] ? lvl_r[1] : dev_out[1];
endmodule // eit_pin_src

/* verification/tb_top.sv */
`timescale 1ns/100ps

module tb_top;
    localparam int LIMIT = 5000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    eit_pkg::eit_cmd_t cmd = '0;
    logic irq_ack = 1'b0;
    logic irq_req, skip_next, presc_tick, skip_seen;
    eit_pkg::eit_src_t irq_src;
    eit_pkg::eit_stat_t status;
    logic [1:0] want = 2'h3;
    logic [1:0] pin, dev_out, dev_oe_n;
    logic [7:0] cnt;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int t_mark;
    int ticks = 0;
    int k_mark;

    // Clock and a free cycle count for periods and the hang limit.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (presc_tick) ticks <= ticks + 1;
        if (cyc == LIMIT) begin
            errors++;
            give_verdict();
        end
    end

    eit_irq_top DUT (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd(cmd), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_src(irq_src), .skip_next(skip_next),
        .ext_irq_pin_zero_in(pin[0]), .ext_irq_pin_zero_out(dev_out[0]),
        .ext_irq_pin_zero_oe_n(dev_oe_n[0]), .ext_irq_pin_one_in(pin[1]),
        .ext_irq_pin_one_out(dev_out[1]), .ext_irq_pin_one_oe_n(dev_oe_n[1]),
        .status(status), .prescaler_output_clock(presc_tick));

    eit_pin_src SRC (.clk(clk), .rst(rst), .want(want), .dev_out(dev_out),
        .dev_oe_n(dev_oe_n), .pin(pin));

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    // One instruction; it leaves an idle cycle so the strobe never
    // changes twice in one time step.
    task automatic issue(input eit_pkg::eit_op_t op, input logic [3:0] a,
                         input logic [3:0] b);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd = {op, a, b};
        @(negedge clk);
        cmd_valid = 1'b0;
        skip_seen = skip_next;
    endtask

    function automatic logic flag(input int i);
        return i == 0 ? status.ext0_flag :
               i == 1 ? status.ext1_flag : status.timer_two_flag;
    endfunction

    task automatic wait_flag(input int i);
        for (int n = 0; n < 40 && flag(i) !== 1'b1; n++)
            @(negedge clk);
    endtask

    // Clears a flag with its skip test; the source enable must be 0 here.
    task automatic clear(input int i);
        logic was;
        was = flag(i);
        issue(i == 0 ? eit_pkg::OP_SKIP_TEST_EXT0 : i == 1 ?
              eit_pkg::OP_SKIP_TEST_EXT1 : eit_pkg::OP_SKIP_TEST_TIMER_TWO,
              4'h0, 4'h0);
        check(8'(skip_seen), 8'(was));
        check(8'(flag(i)), 8'h00);
    endtask

    // Walks one pending source through its enable, the global enable
    // and the acknowledge.
    task automatic gate(input int i, input int b, input eit_pkg::eit_src_t s);
        check(8'(flag(i)), 8'h01);
        issue(eit_pkg::OP_ENABLE_ALL_IRQ, 4'h0, 4'h0);
        check(8'(irq_req), 8'h00);
        issue(eit_pkg::OP_WRITE_SOURCE_ENABLE, 4'h1 << b, 4'h0);
        check(8'(irq_req), 8'h01);
        check(8'(irq_src), 8'(s));
        issue(eit_pkg::OP_DISABLE_ALL_IRQ, 4'h0, 4'h0);
        check(8'(irq_req), 8'h00);
        issue(eit_pkg::OP_ENABLE_ALL_IRQ, 4'h0, 4'h0);
        check(8'(irq_req), 8'h01);
        @(negedge clk);
        irq_ack = 1'b1;
        @(negedge clk);
        irq_ack = 1'b0;
        check({6'h0, irq_req, flag(i)}, 8'h00);
        issue(eit_pkg::OP_WRITE_SOURCE_ENABLE, 4'h0, 4'h0);
    endtask

    // Measures the distance between two timer flags in clocks.
    task automatic period(input int exp);
        wait_flag(2);
        clear(2);
        wait_flag(2);
        t_mark = cyc;
        k_mark = ticks;
        clear(2);
        wait_flag(2);
        check(8'(cyc - t_mark), 8'(exp));
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst = 1'b0;
        check({status.source_enable, status.ext0_ctrl}, 8'h00);
        check({status.ext1_ctrl, status.timer_two_ctrl}, 8'h00);
        check({5'h0, status.inte, irq_req, dev_oe_n[0]}, 8'h01);
        check(status.timer_two_count, 8'hFF);
        $display("Test reset done");

        issue(eit_pkg::OP_WRITE_PORT3, 4'h2, 4'h0);
        check({4'h0, dev_oe_n, pin}, 8'h0A);
        issue(eit_pkg::OP_WRITE_PORT3, 4'h3, 4'h0);
        check(8'(dev_oe_n), 8'h03);
        issue(eit_pkg::OP_WRITE_EXT0_CTRL, 4'hA, 4'h0);
        check(8'(status.ext0_ctrl), 8'h0A);
        repeat (6) @(negedge clk);
        clear(0);
        want[0] = 1'b0;
        wait_flag(0);
        check(8'(flag(0)), 8'h01);
        clear(0);
        repeat (12) @(negedge clk);
        check(8'(flag(0)), 8'h00);
        want[0] = 1'b1;
        wait_flag(0);
        check(8'(flag(0)), 8'h01);
        gate(0, 0, eit_pkg::SRC_EXT0);
        $display("Test external zero done");

        issue(eit_pkg::OP_WRITE_EXT1_CTRL, 4'h8, 4'h0);
        repeat (6) @(negedge clk);
        clear(1);
        want[1] = 1'b0;
        wait_flag(1);
        check(8'(flag(1)), 8'h01);
        clear(1);
        want[1] = 1'b1;
        repeat (12) @(negedge clk);
        check(8'(flag(1)), 8'h00);
        want[1] = 1'b0;
        wait_flag(1);
        gate(1, 1, eit_pkg::SRC_EXT1);
        issue(eit_pkg::OP_WRITE_EXT1_CTRL, 4'hC, 4'h0);
        clear(1);
        want[1] = 1'b1;
        wait_flag(1);
        check(8'(flag(1)), 8'h01);
        clear(1);
        want[1] = 1'b0;
        repeat (12) @(negedge clk);
        check(8'(flag(1)), 8'h00);
        $display("Test external one done");

        issue(eit_pkg::OP_WRITE_EXT0_CTRL, 4'h2, 4'h0);
        repeat (6) @(negedge clk);
        clear(0);
        want[0] = 1'b0;
        repeat (12) @(negedge clk);
        check(8'(flag(0)), 8'h00);
        $display("Test input off done");

        issue(eit_pkg::OP_WRITE_TIMER_TWO_CTRL, 4'h1, 4'h0);
        issue(eit_pkg::OP_WRITE_PRESCALER_CTRL, 4'h0, 4'h0);
        issue(eit_pkg::OP_LOAD_TIMER_TWO_RELOAD, 4'h0, 4'h2);
        issue(eit_pkg::OP_LOAD_PRESCALER_RELOAD, 4'h0, 4'h1);
        check(status.timer_two_count, 8'h02);
        clear(2);
        issue(eit_pkg::OP_WRITE_PRESCALER_CTRL, 4'h1, 4'h0);
        check(8'(status.prescaler_run), 8'h01);
        issue(eit_pkg::OP_WRITE_TIMER_TWO_CTRL, 4'h5, 4'h0);
        period(18);
        check(8'(ticks - k_mark), 8'h03);
        issue(eit_pkg::OP_WRITE_TIMER_TWO_CTRL, 4'h4, 4'h0);
        period(9);
        issue(eit_pkg::OP_WRITE_TIMER_TWO_CTRL, 4'h1, 4'h0);
        cnt = status.timer_two_count;
        repeat (30) @(negedge clk);
        check(status.timer_two_count, cnt);
        issue(eit_pkg::OP_WRITE_TIMER_TWO_CTRL, 4'h6, 4'h0);
        repeat (30) @(negedge clk);
        check(status.timer_two_count, cnt);
        gate(2, 3, eit_pkg::SRC_TIMER_TWO);
        $display("Test timer two done");
        give_verdict();
    end
endmodule // tb_top
